// *** verilog/srasl_slave.v ***
// How it works
// RL1: device is only a target; it never drives the clock line.
// RL2: host makes every clock pulse; data line ownership alternates.
// RL3: lines are only pulled low or released; pull-ups give high.
// RL4: bytes go most significant bit first, sampled while clock high.
// RL5: data falling while clock high is a start; then hear address.
// RL6: first byte holds seven address bits then the direction bit.
// RL7: answer address 1000101; direction one reads, zero writes.
// RL8: host releases data after address; device pulls low on ninth clock.
// RL9: with no acknowledge the host stops and abandons the transfer.
// RL10: each byte takes nine clocks: eight data and one acknowledge.
// RL11: first write byte after the address loads the index register.
// RL12: later write bytes store at the index, then index increments.
// RL13: device acknowledges each received write byte.
// RL14: host ends any sequence with a stop condition.
// RL15: reads start with a write of address and index, then stop or restart.
// RL16: read phase resends address with direction one; device shifts data.
// RL17: after eight read bits device releases data; host acknowledges.
// RL18: host ends a read with a negative acknowledge then a stop.
// RL19: index advances after each read byte; release after a nack.
// RL20: a non-matching address leaves the device silent until next start.
`include "srasl_regs.vh"

module srasl_slave #(
  parameter IDX_W = 8
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire host_serial_clock,
  input wire host_serial_data_in,
  output reg host_serial_data_out,
  output reg host_serial_data_oe,
  output reg host_serial_clock_out,
  output reg host_serial_clock_oe,
  output reg [IDX_W-1:0] reg_index,
  input wire [7:0] reg_rdata,
  output reg reg_wr,
  output reg [IDX_W-1:0] reg_waddr,
  output reg [7:0] reg_wdata,
  output reg busy
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RD = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  function [IDX_W-1:0] idx_next;
    input [IDX_W-1:0] idx;
    begin
      idx_next = idx + {{(IDX_W-1){1'b0}}, 1'b1};
    end
  endfunction

  wire [1:0] lines;
  reg scl_d;
  reg sda_d;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg dir_rd;
  reg got_index;
  reg nack;

  srasl_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({host_serial_clock, host_serial_data_in}),
    .q(lines)
  );

  wire scl = lines[1];
  wire sda = lines[0];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_seen = scl & scl_d & sda_d & ~sda; // RL5
  wire stop_seen = scl & scl_d & ~sda_d & sda;
  wire byte_done = (cnt == `SRASL_BYTE_BITS); // RL10

  always @(posedge clk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      dir_rd <= 1'b0;
      got_index <= 1'b0;
      nack <= 1'b0;
      reg_index <= `SRASL_IDX_RST;
      reg_wr <= 1'b0;
      reg_waddr <= `SRASL_IDX_RST;
      reg_wdata <= 8'h00;
      busy <= 1'b0;
      host_serial_data_out <= 1'b0;
      host_serial_data_oe <= 1'b0;
      host_serial_clock_out <= 1'b0;
      host_serial_clock_oe <= 1'b0;
    end
    else if (ce)
    begin
      scl_d <= scl;
      sda_d <= sda;
      reg_wr <= 1'b0;
      // clock line is never driven; only the low level is ever offered
      host_serial_clock_oe <= 1'b0; // RL1
      host_serial_data_out <= 1'b0; // RL3
      busy <= (state != ST_IDLE);
      if (start_seen)
      begin
        // a repeated start also lands here, keeping the index
        state <= ST_ADDR; // RL5 RL15
        cnt <= 4'h0;
        host_serial_data_oe <= 1'b0;
      end
      else if (stop_seen)
      begin
        state <= ST_IDLE;
        host_serial_data_oe <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_WR:
          begin
            if (scl_rise)
            begin
              sh <= {sh[6:0], sda}; // RL4
              cnt <= cnt + 4'h1;
            end
            else if (scl_fall && byte_done)
            begin
              cnt <= 4'h0;
              if (state == ST_ADDR)
              begin
                if (sh[7:1] == `SRASL_DEV_ADDR) // RL6 RL7
                begin
                  dir_rd <= (sh[0] == `SRASL_DIR_READ); // RL7
                  got_index <= 1'b0;
                  host_serial_data_oe <= 1'b1; // RL8
                  state <= ST_AACK;
                end
                else
                begin
                  state <= ST_IDLE; // RL20
                end
              end
              else
              begin
                host_serial_data_oe <= 1'b1; // RL13
                state <= ST_WACK;
                got_index <= 1'b1;
                if (!got_index)
                begin
                  reg_index <= sh[IDX_W-1:0]; // RL11
                end
                else
                begin
                  reg_wr <= 1'b1; // RL12
                  reg_waddr <= reg_index;
                  reg_wdata <= sh;
                  reg_index <= idx_next(reg_index); // RL12
                end
              end
            end
          end
          ST_AACK:
          begin
            if (scl_fall)
            begin
              cnt <= 4'h0;
              if (dir_rd)
              begin
                // the first read bit goes out as soon as the ack ends
                sh <= {reg_rdata[6:0], 1'b1}; // RL16
                host_serial_data_oe <= ~reg_rdata[7]; // RL4
                state <= ST_RD;
              end
              else
              begin
                host_serial_data_oe <= 1'b0;
                state <= ST_WR;
              end
            end
          end
          ST_WACK:
          begin
            if (scl_fall)
            begin
              host_serial_data_oe <= 1'b0;
              state <= ST_WR;
            end
          end
          ST_RD:
          begin
            if (scl_rise)
            begin
              cnt <= cnt + 4'h1;
            end
            else if (scl_fall)
            begin
              if (byte_done)
              begin
                host_serial_data_oe <= 1'b0; // RL17
                reg_index <= idx_next(reg_index); // RL19
                state <= ST_RACK;
              end
              else
              begin
                sh <= {sh[6:0], 1'b1};
                host_serial_data_oe <= ~sh[7]; // RL4
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              nack <= sda; // RL17
            end
            else if (scl_fall)
            begin
              cnt <= 4'h0;
              if (nack)
              begin
                // host said last byte; stay off the line till a start
                state <= ST_IDLE; // RL19
              end
              else
              begin
                sh <= {reg_rdata[6:0], 1'b1};
                host_serial_data_oe <= ~reg_rdata[7]; // RL16
                state <= ST_RD;
              end
            end
          end
          default:
          begin
            host_serial_data_oe <= 1'b0; // RL20
          end
        endcase
      end
    end
  end

endmodule // srasl_slave

// *** pkg/srasl_regs.vh ***
`ifndef SRASL_REGS_VH
`define SRASL_REGS_VH

// fixed target address, seven bits
`define SRASL_DEV_ADDR 7'h45
// direction bit value that asks for a read
`define SRASL_DIR_READ 1'h1
// bits in one byte on the wire
`define SRASL_BYTE_BITS 4'h8
// index register after reset
`define SRASL_IDX_RST 8'h00
// idle level of both bus lines
`define SRASL_LINE_IDLE 1'h1

`endif

// *** verilog/srasl_sync.v ***
module srasl_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta;

  // the first stage feeds only the second stage
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta <= {W{1'b1}};
      q <= {W{1'b1}};
    end
    else if (ce)
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // srasl_sync

// *** tb/srasl_monitor.sv ***
module srasl_monitor #(
  parameter IDX_W = 8
) (
  input wire clk,
  input wire rst,
  input wire host_serial_clock,
  input wire host_serial_data_out,
  input wire host_serial_data_oe,
  input wire host_serial_clock_out,
  input wire host_serial_clock_oe,
  input wire [IDX_W-1:0] reg_index,
  input wire reg_wr,
  input wire [IDX_W-1:0] reg_waddr,
  input wire busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_oe_hold;
    host_serial_data_oe [*7];
  endsequence
  a_clk_undriven: assert property (!host_serial_clock_oe)
    else $error("clock line driven");
  a_clk_low: assert property (!host_serial_clock_out)
    else $error("clock out not low");
  a_data_low: assert property (!host_serial_data_out)
    else $error("data out not low");
  a_oe_rise_low: assert property ($rose(host_serial_data_oe)
    |-> !host_serial_clock) else $error("data moved, clock high");
  a_oe_whole_bit: assert property ($rose(host_serial_data_oe)
    |=> s_oe_hold) else $error("data pull too short");
  a_wr_one_cycle: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse too long");
  a_idx_after_wr: assert property (reg_wr
    |-> ##[0:2] reg_index == reg_waddr + 1'h1) else $error("no index step");
  a_oe_when_busy: assert property (host_serial_data_oe |-> busy)
    else $error("data pulled while idle");
endmodule // srasl_monitor

bind srasl_slave srasl_monitor #(.IDX_W(IDX_W)) srasl_monitor_i (.clk, .rst,
  .host_serial_clock, .host_serial_data_out, .host_serial_data_oe,
  .host_serial_clock_out, .host_serial_clock_oe, .reg_index, .reg_wr,
  .reg_waddr, .busy);

// *** tb/srasl_host.sv ***
module srasl_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic m_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'h1;
    m_low = 1'h0;
  end
  // clock and data change together only where the clock stays put
  task automatic step(input logic c, input logic m, input int n);
    scl = c;
    m_low = m;
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic s);
    step(1'h0, !b, 2);
    step(1'h1, !b, 2);
    s = sda;
    step(1'h1, !b, 2);
    step(1'h0, !b, 2);
  endtask
  task automatic start;
    step(1'h0, 1'h0, 2);
    step(1'h1, 1'h0, 4);
    step(1'h1, 1'h1, 4);
    step(1'h0, 1'h1, 2);
  endtask
  task automatic stop;
    step(1'h0, 1'h1, 2);
    step(1'h1, 1'h1, 4);
    step(1'h1, 1'h0, 8);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai,
    output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ai, a);
  endtask
endmodule // srasl_host

// *** tb/srasl_slave_tb.sv ***
module srasl_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic ce = 1'h1;
  logic scl, m_low, a;
  logic [7:0] r;
  logic [15:0] wq[$];
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  wire oe, d_o, c_o, c_oe, wr, busy;
  wire [7:0] idx, wa, wd;
  wire [7:0] rd = idx ^ 8'h5a;
  // pull-ups: a released line reads high
  wire sda = !(oe && !d_o || m_low);
  wire scl_w = scl && !(c_oe && !c_o);
  srasl_slave srasl_slave_i (.clk(clk), .rst(rst), .ce(ce),
    .host_serial_clock(scl_w), .host_serial_data_in(sda),
    .host_serial_data_out(d_o), .host_serial_data_oe(oe),
    .host_serial_clock_out(c_o), .host_serial_clock_oe(c_oe),
    .reg_index(idx), .reg_rdata(rd), .reg_wr(wr), .reg_waddr(wa),
    .reg_wdata(wd), .busy(busy));
  srasl_host srasl_host_i (.clk(clk), .sda(sda), .scl(scl), .m_low(m_low));
  initial
    forever #4 clk = ~clk;
  always @(posedge clk)
  begin
    if (wr)
      wq.push_back({wa, wd});
    cyc++;
    if (cyc == 8000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic x(input logic [7:0] d, input logic ai);
    srasl_host_i.xfer(d, ai, r, a);
  endtask
  task automatic t_write;
    srasl_host_i.start();
    x(8'h8a, 1'h1);
    chk(a, 16'h0);
    x(8'hfe, 1'h1);
    chk(a, 16'h0);
    x(8'h11, 1'h1);
    x(8'h22, 1'h1);
    chk(a, 16'h0);
    srasl_host_i.stop();
    chk(16'(wq.size()), 16'h2);
    chk(wq.pop_front(), 16'hfe11);
    chk(wq.pop_front(), 16'hff22);
    chk(idx, 16'h0);
    $display("write test done");
  endtask
  task automatic t_read;
    srasl_host_i.start();
    x(8'h8a, 1'h1);
    x(8'h30, 1'h1);
    srasl_host_i.start();
    x(8'h8b, 1'h1);
    chk(a, 16'h0);
    x(8'hff, 1'h0);
    chk(r, 16'h30 ^ 16'h5a);
    x(8'hff, 1'h1);
    chk(r, 16'h31 ^ 16'h5a);
    srasl_host_i.step(1'h0, 1'h0, 4);
    chk(oe, 16'h0);
    chk(idx, 16'h32);
    srasl_host_i.stop();
    $display("read test done");
  endtask
  task automatic t_other;
    srasl_host_i.start();
    x(8'h8c, 1'h1);
    chk(a, 16'h1);
    x(8'h44, 1'h1);
    chk(a, 16'h1);
    srasl_host_i.stop();
    chk(16'(wq.size()), 16'h0);
    srasl_host_i.start();
    x(8'h8a, 1'h1);
    x(8'h80, 1'h1);
    srasl_host_i.stop();
    srasl_host_i.start();
    x(8'h8b, 1'h1);
    x(8'hff, 1'h1);
    chk(r, 16'h80 ^ 16'h5a);
    srasl_host_i.stop();
    $display("address and stop test done");
  endtask
  // with the enable low the whole block, synchroniser too, must stay put
  task automatic t_hold;
    ce = 1'h0;
    srasl_host_i.start();
    x(8'h8a, 1'h1);
    chk(a, 16'h1);
    chk(busy, 16'h0);
    ce = 1'h1;
    srasl_host_i.stop();
    chk(busy, 16'h0);
    chk(oe, 16'h0);
    $display("clock enable test done");
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    t_write();
    t_read();
    t_other();
    t_hold();
    complete_run();
  end
endmodule // srasl_slave_tb
